/* hdl/lcomp_programmer.v */
// output mode programmer and request server of the light curtain
`timescale 1ns/10ps
`default_nettype none
`include "lcomp_consts.vh"

module lcomp_programmer #(
	parameter [31:0] WIN_CYC = `LCOMP_WIN_CYC
) (
	input wire clk, // 125 MHz clock
	input wire nrst, // power reset, active low
	input wire [7:0] rxByte, // received byte
	input wire rxValid, // received byte strobe
	input wire [15:0] measPattern, // all-eye bit pattern
	input wire [15:0] measLow, // lowest covered eye
	input wire [15:0] measTop, // topmost covered eye
	input wire [15:0] measCount, // covered count
	input wire [15:0] measFree, // first free eye
	output reg [15:0] txWord, // measurement to send
	output reg txValid, // word valid
	input wire txReady, // transmitter accepts word
	output reg rxEnable, // line direction: receive
	output reg progWindow, // programming window open
	output reg [1:0] styleOut, // current output style
	output reg [2:0] measOut // current measurement select
);
	localparam [2:0] ST_P0 = 3'h0;
	localparam [2:0] ST_P1 = 3'h1;
	localparam [2:0] ST_P2 = 3'h2;
	localparam [2:0] ST_P3 = 3'h3;
	localparam [2:0] ST_SEL = 3'h4;
	localparam [2:0] ST_RUN = 3'h5;

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [31:0] timer_reg;
	reg [31:0] timer_next;
	reg [1:0] style_reg;
	reg [1:0] style_next;
	reg [2:0] meas_reg;
	reg [2:0] meas_next;
	reg [7:0] rxByte_reg;
	reg rxValid_reg;
	reg reqValid;
	reg [2:0] reqMeas;
	reg selOk;
	reg [1:0] selSty;
	reg [2:0] selMeas;
	reg [7:0] expByte;
	wire bufReady;
	wire [2:0] headMeas;
	wire headValid;

	// register the incoming strobe so decode sees stable data
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rxByte_reg <= 8'h00;
			rxValid_reg <= 1'b0;
		end
		else
		begin
			rxByte_reg <= rxByte;
			rxValid_reg <= rxValid;
		end
	end

	// prefix byte expected in each state
	always @*
	begin
		case (state_reg)
			ST_P0: expByte = `LCOMP_PRE0;
			ST_P1: expByte = `LCOMP_PRE1;
			ST_P2: expByte = `LCOMP_PRE2;
			ST_P3: expByte = `LCOMP_PRE3;
			default: expByte = 8'h00;
		endcase
	end

	// mode byte decode; no continuous bit-pattern code exists
	always @*
	begin
		selOk = 1'b1;
		selSty = `LCOMP_STY_ANY;
		selMeas = `LCOMP_MEAS_TOP;
		case (rxByte_reg)
			`LCOMP_ANY_PAT: selMeas = `LCOMP_MEAS_PAT;
			`LCOMP_ANY_LOW: selMeas = `LCOMP_MEAS_LOW;
			`LCOMP_ANY_TOP: selMeas = `LCOMP_MEAS_TOP;
			`LCOMP_ANY_CNT: selMeas = `LCOMP_MEAS_CNT;
			`LCOMP_ANY_FREE: selMeas = `LCOMP_MEAS_FREE;
			`LCOMP_REQDEP: selSty = `LCOMP_STY_REQ;
			`LCOMP_CONT_CNT:
			begin
				selSty = `LCOMP_STY_CONT;
				selMeas = `LCOMP_MEAS_CNT;
			end
			`LCOMP_CONT_TOP:
			begin
				selSty = `LCOMP_STY_CONT;
				selMeas = `LCOMP_MEAS_TOP;
			end
			`LCOMP_CONT_LOW:
			begin
				selSty = `LCOMP_STY_CONT;
				selMeas = `LCOMP_MEAS_LOW;
			end
			`LCOMP_CONT_FREE:
			begin
				selSty = `LCOMP_STY_CONT;
				selMeas = `LCOMP_MEAS_FREE;
			end
			default: selOk = 1'b0;
		endcase
	end

	// programming window sequencer
	always @*
	begin
		state_next = state_reg;
		timer_next = timer_reg;
		style_next = style_reg;
		meas_next = meas_reg;
		case (state_reg)
			ST_P0, ST_P1, ST_P2, ST_P3, ST_SEL:
			begin
				timer_next = timer_reg + 32'h0000_0001;
				if (rxValid_reg)
				begin
					timer_next = 32'h0000_0000;
					if (state_reg == ST_SEL)
					begin
						state_next = ST_RUN;
						if (selOk)
						begin
							style_next = selSty;
							meas_next = selMeas;
						end
					end
					else if (rxByte_reg == expByte)
						state_next = state_reg + 3'h1;
					else
						state_next = ST_RUN;
				end
				else if (timer_reg >= WIN_CYC - 32'h0000_0001)
					state_next = ST_RUN;
			end
			ST_RUN: state_next = ST_RUN;
			default: state_next = ST_RUN;
		endcase
	end

	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg <= ST_P0;
			timer_reg <= 32'h0000_0000;
			style_reg <= `LCOMP_RST_STY;
			meas_reg <= `LCOMP_RST_MEAS;
		end
		else
		begin
			state_reg <= state_next;
			timer_reg <= timer_next;
			style_reg <= style_next;
			meas_reg <= meas_next;
		end
	end

	// request decode in run state
	always @*
	begin
		reqValid = 1'b0;
		reqMeas = meas_reg;
		if (state_reg == ST_RUN)
		begin
			case (style_reg)
				`LCOMP_STY_ANY: reqValid = rxValid_reg;
				`LCOMP_STY_REQ:
				begin
					reqValid = rxValid_reg;
					case (rxByte_reg)
						`LCOMP_REQ_PAT: reqMeas = `LCOMP_MEAS_PAT;
						`LCOMP_REQ_LOW: reqMeas = `LCOMP_MEAS_LOW;
						`LCOMP_REQ_TOP: reqMeas = `LCOMP_MEAS_TOP;
						`LCOMP_REQ_CNT: reqMeas = `LCOMP_MEAS_CNT;
						`LCOMP_REQ_FREE: reqMeas = `LCOMP_MEAS_FREE;
						default: reqValid = 1'b0;
					endcase
				end
				`LCOMP_STY_CONT: reqValid = 1'b1;
				default: reqValid = 1'b0;
			endcase
		end
	end

	// requests that find the buffer full are dropped
	lcomp_buf2 i_lcomp_buf2 (
		.clk(clk),
		.nrst(nrst),
		.inData(reqMeas),
		.inValid(reqValid & bufReady),
		.inReady(bufReady),
		.outData(headMeas),
		.outValid(headValid),
		.outReady(~txValid | txReady)
	);

	// output stage samples measurement when word leaves buffer
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			txWord <= 16'h0000;
			txValid <= 1'b0;
			rxEnable <= 1'b1;
			progWindow <= 1'b1;
			styleOut <= `LCOMP_RST_STY;
			measOut <= `LCOMP_RST_MEAS;
		end
		else
		begin
			if (!txValid || txReady)
			begin
				txValid <= headValid;
				case (headMeas)
					`LCOMP_MEAS_PAT: txWord <= measPattern;
					`LCOMP_MEAS_LOW: txWord <= measLow;
					`LCOMP_MEAS_TOP: txWord <= measTop;
					`LCOMP_MEAS_CNT: txWord <= measCount;
					default: txWord <= measFree;
				endcase
			end
			// half-duplex: continuous style never listens again
			rxEnable <= (state_next != ST_RUN) | (style_next != `LCOMP_STY_CONT);
			progWindow <= (state_next != ST_RUN);
			styleOut <= style_next;
			measOut <= meas_next;
		end
	end
endmodule
`default_nettype wire

/* hdl/lcomp_consts.vh */
// constants for the light curtain output mode programmer
`ifndef LCOMP_CONSTS_VH
`define LCOMP_CONSTS_VH

// unlock prefix
`define LCOMP_PRE0 8'h6D
`define LCOMP_PRE1 8'h6C
`define LCOMP_PRE2 8'h76
`define LCOMP_PRE3 8'h74

// any-request mode selectors
`define LCOMP_ANY_PAT 8'h60
`define LCOMP_ANY_LOW 8'h40
`define LCOMP_ANY_TOP 8'h20
`define LCOMP_ANY_CNT 8'h80
`define LCOMP_ANY_FREE 8'h32
// request-dependent mode selector
`define LCOMP_REQDEP 8'h10
// continuous mode selectors
`define LCOMP_CONT_CNT 8'h08
`define LCOMP_CONT_TOP 8'h28
`define LCOMP_CONT_LOW 8'h48
`define LCOMP_CONT_FREE 8'h39

// request bytes in request-dependent mode
`define LCOMP_REQ_PAT 8'h60
`define LCOMP_REQ_LOW 8'h40
`define LCOMP_REQ_TOP 8'h20
`define LCOMP_REQ_CNT 8'h80
`define LCOMP_REQ_FREE 8'h32

// output style codes
`define LCOMP_STY_ANY 2'h0
`define LCOMP_STY_REQ 2'h1
`define LCOMP_STY_CONT 2'h2

// measurement select codes
`define LCOMP_MEAS_PAT 3'h0
`define LCOMP_MEAS_LOW 3'h1
`define LCOMP_MEAS_TOP 3'h2
`define LCOMP_MEAS_CNT 3'h3
`define LCOMP_MEAS_FREE 3'h4

// reset values: topmost eye, continuous
`define LCOMP_RST_STY `LCOMP_STY_CONT
`define LCOMP_RST_MEAS `LCOMP_MEAS_TOP

// programming window
`define LCOMP_WIN_MS 2500
`define LCOMP_CLK_KHZ 125000
`define LCOMP_WIN_CYC (`LCOMP_WIN_MS * `LCOMP_CLK_KHZ)

`endif

/* hdl/lcomp_buf2.v */
// two-entry valid/ready buffer for outgoing measurement words
`timescale 1ns/10ps
`default_nettype none
module lcomp_buf2 (
	input wire clk, // clock
	input wire nrst, // async reset, active low
	input wire [2:0] inData, // measurement select in
	input wire inValid, // input valid
	output wire inReady, // room available
	output reg [2:0] outData, // head word
	output reg outValid, // head valid
	input wire outReady // consumer ready
);
	reg [2:0] spare_reg;
	reg spareValid_reg;

	// a word is taken whenever the head moves on or the spare slot is free
	assign inReady = ~outValid | outReady | ~spareValid_reg;

	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			outData <= 3'h0;
			outValid <= 1'b0;
			spare_reg <= 3'h0;
			spareValid_reg <= 1'b0;
		end
		else
		begin
			if (!outValid || outReady)
			begin
				if (spareValid_reg)
				begin
					outData <= spare_reg;
					outValid <= 1'b1;
					spareValid_reg <= inValid;
					spare_reg <= inData;
				end
				else
				begin
					outData <= inData;
					outValid <= inValid;
				end
			end
			else if (inValid && !spareValid_reg)
			begin
				spare_reg <= inData;
				spareValid_reg <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* bench/lcomp_props.sv */
// assertions on the ports of the output mode programmer
`timescale 1ns/10ps
`default_nettype none
module lcomp_props_chk #(
	parameter [31:0] WIN_CYC = 50
) (
	input wire logic clk, // clock
	input wire logic nrst, // reset, active low
	input wire logic rxValid, // byte strobe
	input wire logic [15:0] txWord, // word out
	input wire logic txValid, // word valid
	input wire logic txReady, // sink accept
	input wire logic rxEnable, // receive direction
	input wire logic progWindow, // window open
	input wire logic [1:0] styleOut, // style
	input wire logic [2:0] measOut // measurement
);
	logic [31:0] idle_reg;
	// idle cycles inside the window
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			idle_reg <= 32'h0000_0000;
		else if (rxValid || !progWindow)
			idle_reg <= 32'h0000_0000;
		else
			idle_reg <= idle_reg + 32'h0000_0001;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	no_cont_pat_a: assert property (styleOut == 2'h2 |-> measOut != 3'h0)
		else $error("continuous style with bit pattern");
	meas_range_a: assert property (measOut <= 3'h4)
		else $error("measurement select out of range");
	rx_dir_a: assert property (!rxEnable |-> styleOut == 2'h2 && !progWindow)
		else $error("line turned outside continuous run");
	win_rx_a: assert property (progWindow |-> rxEnable)
		else $error("window open but not receiving");
	win_once_a: assert property (!progWindow |=> !progWindow)
		else $error("window reopened without reset");
	win_timeout_a: assert property (idle_reg > WIN_CYC + 2 |-> !progWindow)
		else $error("window outlived its limit");
	mode_lat_a: assert property ($changed(styleOut) |-> $past(rxValid, 2))
		else $error("style changed without a byte");
	hold_mode_a: assert property (!progWindow |=> $stable({styleOut, measOut}))
		else $error("mode changed after window");
	tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txWord))
		else $error("word dropped while stalled");
endmodule
bind lcomp_programmer lcomp_props_chk #(.WIN_CYC(WIN_CYC)) i_lcomp_props_chk (.clk(clk),
	.nrst(nrst), .rxValid(rxValid), .txWord(txWord), .txValid(txValid), .txReady(txReady),
	.rxEnable(rxEnable), .progWindow(progWindow), .styleOut(styleOut), .measOut(measOut));
`default_nettype wire

/* bench/lcomp_host_sink.sv */
// host side model taking measurement words
`timescale 1ns/10ps
`default_nettype none
module lcomp_host_sink (
	input wire logic clk, // clock
	input wire logic nrst, // reset, active low
	input wire logic stall, // hold off acceptance
	input wire logic txValid, // word offered
	input wire logic [15:0] txWord, // word
	output logic txReady, // accept
	output logic [15:0] lastWord, // last accepted word
	output logic [7:0] wordCnt // accepted words
);
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			txReady <= 1'b0;
			lastWord <= 16'h0000;
			wordCnt <= 8'h00;
		end
		else
		begin
			// half rate acceptance
			txReady <= !stall && !txReady;
			if (txValid && txReady)
			begin
				lastWord <= txWord;
				wordCnt <= wordCnt + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench for the output mode programmer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int WIN = 50;
	logic clk = 0, nrst = 0, rxValid = 0, stall = 0, txValid, txReady, rxEnable, progWindow;
	logic [7:0] rxByte = 0, wordCnt, prev;
	logic [15:0] txWord, lastWord;
	logic [1:0] styleOut;
	logic [2:0] measOut;
	logic [15:0] meas [0:4] = '{16'hA5A5, 16'h0003, 16'h000C, 16'h0007, 16'h0001};
	// mode byte, style, measurement
	logic [12:0] tbl [0:9] = '{13'h0C00, 13'h0801, 13'h0402, 13'h1003, 13'h0644,
		13'h0208, 13'h0113, 13'h0512, 13'h0911, 13'h0734};
	int errTotal = 0, checkCount = 0, cyc = 0, i, j, k;
	always #4 clk = ~clk;
	lcomp_programmer #(.WIN_CYC(WIN)) i_lcomp_programmer (.clk(clk), .nrst(nrst),
		.rxByte(rxByte), .rxValid(rxValid), .measPattern(meas[0]), .measLow(meas[1]),
		.measTop(meas[2]), .measCount(meas[3]), .measFree(meas[4]), .txWord(txWord),
		.txValid(txValid), .txReady(txReady), .rxEnable(rxEnable), .progWindow(progWindow),
		.styleOut(styleOut), .measOut(measOut));
	lcomp_host_sink i_lcomp_host_sink (.clk(clk), .nrst(nrst), .stall(stall),
		.txValid(txValid), .txWord(txWord), .txReady(txReady), .lastWord(lastWord),
		.wordCnt(wordCnt));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checkCount++;
		if (got !== exp)
			begin
			errTotal++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic send(input logic [7:0] b);
		@(posedge clk);
		rxByte <= b;
		rxValid <= 1'b1;
		@(posedge clk);
		rxValid <= 1'b0;
	endtask
	task automatic powerUp();
		@(posedge clk);
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
	endtask
	task automatic prefix();
		send(8'h6D);
		send(8'h6C);
		send(8'h76);
		send(8'h74);
	endtask
	task automatic slowSend(input logic [7:0] b);
		tick(WIN - 4);
		send(b);
	endtask
	task automatic expectWord(input logic [15:0] exp);
		prev = wordCnt;
		for (k = 0; k < 60 && wordCnt == prev; k++)
			tick(1);
		check(wordCnt == prev ? 16'hDEAD : lastWord, exp);
	endtask
	task automatic t_defaults();
		powerUp();
		tick(1);
		check({11'h000, styleOut, measOut}, 16'h0012);
		check({14'h0000, progWindow, rxEnable}, 16'h0003);
	endtask
	task automatic t_modes();
		for (i = 0; i < 10; i++)
		begin
			powerUp();
			prefix();
			send(tbl[i][12:5]);
			tick(3);
			check({14'h0000, styleOut}, {14'h0000, tbl[i][4:3]});
			if (tbl[i][4:3] != 2'h1)
				check({13'h0000, measOut}, {13'h0000, tbl[i][2:0]});
			if (tbl[i][4:3] == 2'h0)
				send(8'h55);
			if (tbl[i][4:3] != 2'h1)
				expectWord(meas[tbl[i][2:0]]);
			if (tbl[i][4:3] == 2'h2)
			begin
				check({15'h0000, rxEnable}, 16'h0000);
				expectWord(meas[tbl[i][2:0]]);
			end
			if (tbl[i][4:3] == 2'h1)
			begin
				for (j = 0; j < 5; j++)
				begin
					send(tbl[j][12:5]);
					expectWord(meas[j]);
				end
				send(8'h55);
				tick(20);
				check({8'h00, wordCnt}, {8'h00, prev} + 16'h0001);
			end
		end
	endtask
	task automatic t_refuse();
		powerUp();
		send(8'h6D);
		send(8'h00);
		tick(3);
		check({10'h000, progWindow, styleOut, measOut}, 16'h0012);
		expectWord(meas[2]);
		powerUp();
		prefix();
		send(8'h0C);
		tick(3);
		check({10'h000, progWindow, styleOut, measOut}, 16'h0012);
		powerUp();
		tick(WIN + 2);
		check({10'h000, progWindow, styleOut, measOut}, 16'h0012);
		check({15'h0000, rxEnable}, 16'h0000);
		expectWord(meas[2]);
		powerUp();
		send(8'h6D);
		tick(WIN + 5);
		send(8'h6C);
		send(8'h76);
		send(8'h74);
		send(8'h60);
		tick(3);
		check({10'h000, progWindow, styleOut, measOut}, 16'h0012);
	endtask
	task automatic t_buffer();
		powerUp();
		prefix();
		send(8'h20);
		stall <= 1'b1;
		tick(3);
		prev = wordCnt;
		for (j = 0; j < 6; j++)
			send(8'h55);
		tick(5);
		check({15'h0000, txValid}, 16'h0001);
		@(posedge clk);
		stall <= 1'b0;
		tick(40);
		check({8'h00, wordCnt - prev}, 16'h0003);
		check(lastWord, meas[2]);
	endtask
	task automatic t_slow();
		powerUp();
		slowSend(8'h6D);
		slowSend(8'h6C);
		slowSend(8'h76);
		slowSend(8'h74);
		slowSend(8'h48);
		tick(3);
		check({10'h000, progWindow, styleOut, measOut}, 16'h0011);
		expectWord(meas[1]);
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", checkCount, errTotal);
		if (errTotal == 0 && checkCount > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 20000)
		begin
			errTotal++;
			end_sim();
		end
	end
	initial
	begin
		t_defaults();
		t_modes();
		t_refuse();
		t_buffer();
		t_slow();
		end_sim();
	end
endmodule
`default_nettype wire
